// file: rtl/rsx_exec.sv
// rotate-right, set-file, sleep and subtract-from-literal instruction executor
//
// Contract
// - rotate_right_nocarry_op rotates the addressed register right by exactly one bit.
// - the rotate result goes to working_register when d is 0 and back to the file when d is 1.
// - set_file_ones_op with s equal 0 loads FFh into the file and into working_register.
// - set_file_ones_op with s equal 1 loads FFh into the file only and keeps working_register.
// - set_file_ones_op writes the file and, when selected, working_register in Q4.
// - the sleep opcode clears powerdown_flag_n to zero.
// - sleep sets timeout_flag_n to one.
// - sleep clears the watchdog_counter to 00h and its postscaler to zero.
// - after sleep the core enters the sleep state with the oscillator halted until wake-up.
// - a watchdog wake-up from sleep clears timeout_flag_n.
// - sub_work_from_literal_op computes literal minus working_register into working_register.
// - the subtraction updates overflow, carry, digit carry and zero flags.
// - carry is one when the difference is zero or positive and zero on a borrow.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module rsx_exec (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  // instruction and phase
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic [1:0] q_phase,
  // file register read
  input wire logic [7:0] file_rdata,
  // wake-up events (same clock)
  input wire logic wake_wdt,
  input wire logic wake_other,
  // file register write
  output logic file_we,
  output logic [7:0] file_addr,
  output logic [7:0] file_wdata,
  // core state
  output logic [7:0] working_register,
  output logic [3:0] alu_flags,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic sleep_active,
  output logic osc_halt,
  output logic wdt_clear
);
  ////////////////////////////////////////////////////////////////////////////
  // registers and their next values
  logic [7:0] src_q;
  logic [7:0] src_d;
  logic [7:0] res_q;
  logic [7:0] res_d;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [7:0] w_q;
  logic [7:0] w_d;
  logic we_q;
  logic we_d;
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic sleep_q;
  logic sleep_d;
  logic to_n_q;
  logic to_n_d;
  logic pwrdn_n_q;
  logic pwrdn_n_d;
  logic clr_q;
  logic clr_d;
  ////////////////////////////////////////////////////////////////////////////
  // decode
  rsx_pkg::rsx_phase_t phase;
  wire logic ph_q2;
  wire logic ph_q3;
  wire logic ph_q4;
  wire logic is_rot;
  wire logic is_set;
  wire logic is_sub;
  wire logic is_slp;
  wire logic ds;
  wire logic [7:0] operand;
  wire logic run;
  assign phase = rsx_pkg::rsx_phase_t'(q_phase);
  assign ph_q2 = (phase == rsx_pkg::RSX_Q2);
  assign ph_q3 = (phase == rsx_pkg::RSX_Q3);
  assign ph_q4 = (phase == rsx_pkg::RSX_Q4);
  // d and s share bit 8, so rotate and set compare bits 15 to 9 only
  assign is_rot = instr_valid && (instr[15:9] == rsx_pkg::ROT_OPC_HI);
  assign is_set = instr_valid && (instr[15:9] == rsx_pkg::SET_FILE_ONES_OP_OPC_HI);
  assign is_sub = instr_valid && (instr[15:8] == rsx_pkg::SUBL_OPC_HI);
  assign is_slp = instr_valid && (instr == rsx_pkg::SLEEP_OPC);
  assign ds = instr[rsx_pkg::DS_BIT];
  assign operand = instr[7:0];
  // instructions run only while awake and clk_en is high; sleep freezes the datapath registers
  assign run = clk_en && !sleep_q;
  ////////////////////////////////////////////////////////////////////////////
  // arithmetic
  wire logic [7:0] w_inv;
  wire logic [8:0] diff;
  wire logic [4:0] dlow;
  wire logic ovf;
  wire logic zero;
  wire logic [7:0] rot;
  assign w_inv = ~w_q;
  // literal minus w as an add of the complement: carry out means no borrow
  assign diff = {1'b0, operand} + {1'b0, w_inv} + 9'h001;
  assign dlow = {1'b0, operand[3:0]} + {1'b0, w_inv[3:0]} + 5'h01;
  assign ovf = (operand[7] != w_q[7]) && (diff[7] != operand[7]);
  assign zero = (diff[7:0] == 8'h00);
  // rotate right: each bit takes its left neighbour and bit 7 takes bit 0
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_rot
      if (gi == 7)
      begin : g_wrap
        assign rot[gi] = src_q[0];
      end
      else
      begin : g_shift
        assign rot[gi] = src_q[gi + 1];
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // q3 execute; rotate and set leave the flags alone
  always_comb
  begin
    res_d = res_q;
    flags_d = flags_q;
    if (ph_q3)
    begin
      if (is_rot)
        res_d = rot;
      else if (is_set)
        res_d = rsx_pkg::ALL_ONES;
      else if (is_sub)
      begin
        res_d = diff[7:0];
        flags_d[rsx_pkg::FLAG_C] = diff[8];
        flags_d[rsx_pkg::FLAG_DIGIT] = dlow[4];
        flags_d[rsx_pkg::FLAG_Z] = zero;
        flags_d[rsx_pkg::FLAG_OVF] = ovf;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // q2 source latch and q4 writeback selection
  wire logic wr_file;
  wire logic wr_w;
  assign wr_file = ph_q4 && ((is_rot && ds) || is_set);
  assign wr_w = ph_q4 && ((is_rot && !ds) || (is_set && !ds) || is_sub);
  assign src_d = ph_q2 ? file_rdata : src_q;
  assign w_d = wr_w ? res_q : w_q;
  assign we_d = run && wr_file;
  assign addr_d = wr_file ? operand : addr_q;
  assign wdata_d = wr_file ? res_q : wdata_q;
  ////////////////////////////////////////////////////////////////////////////
  // sleep and wake; a wake event ends sleep whatever the q phase
  wire logic slp_go;
  wire logic wake;
  assign slp_go = run && is_slp && ph_q3;
  assign wake = sleep_q && (wake_wdt || wake_other);
  // sleep entry wins over a wake event in the same cycle
  assign sleep_d = slp_go ? 1'b1 : (wake ? 1'b0 : sleep_q);
  assign pwrdn_n_d = slp_go ? 1'b0 : pwrdn_n_q;
  assign to_n_d = slp_go ? 1'b1 : ((wake && wake_wdt) ? 1'b0 : to_n_q);
  // one-cycle request; the watchdog block clears its count and postscaler
  assign clr_d = slp_go;
  ////////////////////////////////////////////////////////////////////////////
  // datapath registers, frozen while asleep or disabled
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      src_q <= rsx_pkg::BYTE_RESET;
    end
    else if (run)
    begin
      src_q <= src_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      res_q <= rsx_pkg::BYTE_RESET;
    end
    else if (run)
    begin
      res_q <= res_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      flags_q <= rsx_pkg::FLAGS_RESET;
    end
    else if (run)
    begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      w_q <= rsx_pkg::W_RESET;
    end
    else if (run)
    begin
      w_q <= w_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_q <= rsx_pkg::BYTE_RESET;
    end
    else if (run)
    begin
      addr_q <= addr_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wdata_q <= rsx_pkg::BYTE_RESET;
    end
    else if (run)
    begin
      wdata_q <= wdata_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // control registers; these keep running while asleep so a wake can land
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      we_q <= 1'b0;
    end
    else if (clk_en)
    begin
      we_q <= we_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sleep_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sleep_q <= sleep_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      to_n_q <= 1'b1;
    end
    else if (clk_en)
    begin
      to_n_q <= to_n_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pwrdn_n_q <= 1'b1;
    end
    else if (clk_en)
    begin
      pwrdn_n_q <= pwrdn_n_d;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      clr_q <= 1'b0;
    end
    else if (clk_en)
    begin
      clr_q <= clr_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign file_we = we_q;
  assign file_addr = addr_q;
  assign file_wdata = wdata_q;
  assign working_register = w_q;
  assign alu_flags = flags_q;
  assign timeout_flag_n = to_n_q;
  assign powerdown_flag_n = pwrdn_n_q;
  assign sleep_active = sleep_q;
  assign osc_halt = sleep_q;
  assign wdt_clear = clr_q;
endmodule // rsx_exec

// file: rtl/rsx_pkg.sv
// package: opcodes, q-phase codes and flag positions for the rotate/set/sleep/subtract executor
package rsx_pkg;
  // q phase of an instruction cycle
  typedef enum logic [1:0] {
    RSX_Q1 = 2'b00,
    RSX_Q2 = 2'b01,
    RSX_Q3 = 2'b10,
    RSX_Q4 = 2'b11
  } rsx_phase_t;
  // opcode patterns (upper byte, with d/s in bit 8 masked off where it applies; sleep as the whole 16-bit word)
  localparam logic [6:0] ROT_OPC_HI = 7'h10;          // 0010 000
  localparam logic [6:0] SET_FILE_ONES_OP_OPC_HI = 7'h15;         // 0010 101
  localparam logic [7:0] SUBL_OPC_HI = 8'hB2;         // 1011 0010
  localparam logic [15:0] SLEEP_OPC = 16'h0003;
  localparam int DS_BIT = 8;
  // alu status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_DIGIT = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OVF = 3;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
endpackage

// file: test/rsx_exec_properties.sv
// checker: port properties of the executor
`timescale 1ns/1ps
module rsx_exec_props (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // watched
  input wire logic [15:0] instr,
  input wire logic [1:0] q_phase,
  input wire logic [7:0] file_rdata,
  input wire logic wake_wdt,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  input wire logic [3:0] alu_flags,
  input wire logic timeout_flag_n,
  input wire logic powerdown_flag_n,
  input wire logic sleep_active,
  input wire logic osc_halt,
  input wire logic wdt_clear
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire logic [7:0] rot_exp = {file_rdata[0], file_rdata[7:1]};
  wire logic run = !sleep_active;
  sequence rot_q4; q_phase == 2'h3 && instr[15:8] == 8'h21 && run; endsequence
  sequence set_q4; q_phase == 2'h3 && instr[15:9] == 7'h15 && run; endsequence
  a_rot_data: assert property (rot_q4 |=> file_we && file_wdata == $past(rot_exp, 3))
    else $error("rotate data");
  a_set_data: assert property (set_q4 |=> file_we && file_wdata == 8'hFF)
    else $error("set data");
  a_we_pulse: assert property (file_we |=> !file_we) else $error("write pulse");
  a_rot_flags: assert property (q_phase == 2'h2 && instr[15:9] == 7'h10 && run |=>
    $stable(alu_flags)) else $error("rotate flags");
  a_sleep_pd: assert property (sleep_active |-> !powerdown_flag_n && osc_halt)
    else $error("sleep state");
  a_sleep_entry: assert property ($rose(sleep_active) |-> timeout_flag_n && wdt_clear)
    else $error("sleep entry");
  a_clear_pulse: assert property (wdt_clear |=> !wdt_clear) else $error("clear pulse");
  a_wdt_wake: assert property (sleep_active && wake_wdt |=> !sleep_active && !timeout_flag_n)
    else $error("wake");
endmodule // rsx_exec_props
bind rsx_exec rsx_exec_props u_props (.clock, .nrst, .instr, .q_phase, .file_rdata, .wake_wdt,
  .file_we, .file_wdata, .alu_flags, .timeout_flag_n, .powerdown_flag_n, .sleep_active,
  .osc_halt, .wdt_clear);

// file: test/testbench.sv
// self-checking bench for the executor
`timescale 1ns/1ps
module testbench;
  logic clock = 0, nrst = 0, instr_valid = 0, wake_wdt = 0, clk_en = 1, file_we, wdt_clear;
  logic sleep_active, osc_halt, timeout_flag_n, powerdown_flag_n;
  logic [15:0] instr = 16'h0000;
  logic [1:0] q_phase = 2'h0;
  logic [7:0] file_rdata = 8'h00, file_addr, file_wdata, working_register;
  logic [3:0] alu_flags;
  int bad_count = 0;
  int n_tests = 0;
  always #2.5 clock = ~clock;
  rsx_exec DUT (.clock, .nrst, .clk_en, .instr, .instr_valid, .q_phase, .file_rdata,
    .wake_wdt, .wake_other(1'b0), .file_we, .file_addr, .file_wdata, .working_register,
    .alu_flags, .timeout_flag_n, .powerdown_flag_n, .sleep_active, .osc_halt, .wdt_clear);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one instruction, four phases; checks land just after the q4 edge
  task automatic exec(input logic [15:0] i, input logic [7:0] r, w, we, f);
    for (int p = 0; p < 4; p++)
    begin
      instr <= i;
      file_rdata <= r;
      instr_valid <= 1'b1;
      q_phase <= p[1:0];
      @(posedge clock);
    end
    // park the port so a held q4 is not executed a second time
    instr_valid <= 1'b0;
    q_phase <= 2'h0;
    #1;
    chk(working_register, w);
    chk({7'h00, file_we}, we);
    chk({4'h0, alu_flags}, f);
    @(posedge clock);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #10000;
    bad_count++;
    finish_test;
  end
  initial
  begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    exec(16'h2A05, 8'h00, 8'hFF, 8'h01, 8'h00);
    chk(file_addr, 8'h05);
    exec(16'h2B06, 8'h00, 8'hFF, 8'h01, 8'h00);
    chk(file_wdata, 8'hFF);
    exec(16'hB202, 8'h00, 8'h03, 8'h00, 8'h00);
    exec(16'hB205, 8'h00, 8'h02, 8'h00, 8'h03);
    exec(16'hB202, 8'h00, 8'h00, 8'h00, 8'h07);
    exec(16'hB27F, 8'h00, 8'h7F, 8'h00, 8'h03);
    exec(16'hB280, 8'h00, 8'h01, 8'h00, 8'h09);
    // clock enable low: nothing may change
    clk_en <= 1'b0;
    exec(16'hB205, 8'h00, 8'h01, 8'h00, 8'h09);
    clk_en <= 1'b1;
    exec(16'h2000, 8'hD7, 8'hEB, 8'h00, 8'h09);
    exec(16'h2122, 8'h01, 8'hEB, 8'h01, 8'h09);
    chk(file_wdata, 8'h80);
    exec(16'h0003, 8'h00, 8'hEB, 8'h00, 8'h09);
    chk({4'h0, powerdown_flag_n, timeout_flag_n, sleep_active, osc_halt}, 8'h07);
    // asleep: this set must not run
    exec(16'h2A05, 8'h00, 8'hEB, 8'h00, 8'h09);
    wake_wdt <= 1'b1;
    @(posedge clock);
    wake_wdt <= 1'b0;
    #1;
    chk({6'h00, sleep_active, timeout_flag_n}, 8'h00);
    finish_test;
  end
endmodule // testbench
